// File: core/eipu_pkg.sv
// constants, register map and source numbering of the event interrupt unit
// assumes one 40 MHz clock, AXI4-Lite register access, same-clock requests
package eipu_pkg;

   // *********************************************************************
   // source counts and numbering
   // *********************************************************************
   localparam int NUM_EV   = 13;
   localparam int NUM_SW   = 7;
   localparam int NUM_TRAP = 16;
   localparam int NUM_EXC  = 6;
   localparam int NUM_NMI  = NUM_EXC + NUM_TRAP;
   localparam int LVL_W    = 4;
   localparam int ID_W     = 6;
   localparam int PF_W     = 3;
   localparam int ST_W     = 4;
   localparam int AW       = 8;

   localparam logic [ID_W-1:0] ID_EXC = 6'h00;
   localparam logic [ID_W-1:0] ID_EV  = 6'h16;
   localparam logic [ID_W-1:0] ID_SW  = 6'h23;

   localparam logic [LVL_W-1:0] LVL_NMI    = 4'hF;
   localparam logic [LVL_W-1:0] LVL_EV_BAS = 4'h8;
   localparam logic [LVL_W-1:0] LVL_EV_MIN = 4'h9;
   localparam logic [LVL_W-1:0] LVL_SW_MAX = 4'h7;

   // enable-bit slot of each event source, sources in rank order
   localparam logic [3:0] EV_SLOT [NUM_EV] = '{
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
      4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};

   localparam int GEN_BIT = 7;
   localparam int EXT0    = 0;
   localparam int EXT1    = 2;
   localparam int PF_HI   = 4;
   localparam logic [7:0] ENL_MASK = 8'hBF;
   localparam logic [7:0] ENH_MASK = 8'hFB;
   localparam logic [7:0] PRI_MASK = 8'h77;
   localparam logic [2:0] PRI_HOLE = 3'h3;

   // *********************************************************************
   // register map
   // *********************************************************************
   localparam logic [AW-1:0] OFS_ENL  = 8'h00;
   localparam logic [AW-1:0] OFS_ENH  = 8'h04;
   localparam logic [AW-1:0] OFS_SRQ  = 8'h08;
   localparam logic [AW-1:0] OFS_SEN  = 8'h0C;
   localparam logic [AW-1:0] OFS_IST  = 8'h10;
   localparam logic [AW-1:0] OFS_IMSK = 8'h14;
   localparam logic [AW-1:0] OFS_STAT = 8'h18;
   localparam logic [AW-1:0] OFS_PRI0 = 8'h20;

   // status bits
   localparam int ST_EV   = 0;
   localparam int ST_SW   = 1;
   localparam int ST_NMI  = 2;
   localparam int ST_WAKE = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/eipu_arb.sv
// highest-level search over a request vector, lower index wins a tie
// assumes levels packed LVL_W bits per request, index 0 in the low bits
`timescale 1ns/100ps
module eipu_arb #(
   parameter int N  = 4,
   parameter int IW = 2
) (
   // candidates
   input  wire logic [N-1:0]                  req,
   input  wire logic [N*eipu_pkg::LVL_W-1:0]  lvl,
   // winner
   output logic                               found,
   output logic [IW-1:0]                      idx,
   output logic [eipu_pkg::LVL_W-1:0]         best
);
   import eipu_pkg::*;

   // strict compare keeps the earlier (better ranked) source on a tie
   always_comb
   begin
      found = 1'b0;
      idx   = '0;
      best  = '0;
      for (int i = 0; i < N; i++)
      begin
         if (req[i] && (lvl[i*LVL_W +: LVL_W] > best))
         begin
            found = 1'b1;
            idx   = IW'(i);
            best  = lvl[i*LVL_W +: LVL_W];
         end
      end
   end

endmodule

// File: core/eipu_top.sv
// event interrupt priority unit: masking, level assignment, arbitration
// assumes requests and core running level come from logic on aclk
`timescale 1ns/100ps
module eipu_top (
   // clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // axi4-lite write address
   input  wire logic [eipu_pkg::AW-1:0]       s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   // axi4-lite read
   input  wire logic [eipu_pkg::AW-1:0]       s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // peripheral side
   input  wire logic [eipu_pkg::NUM_EV-1:0]   ev_req,
   input  wire logic [1:0]                    ext_lvl_mode,
   input  wire logic [eipu_pkg::NUM_EXC-1:0]  exc_req,
   input  wire logic [eipu_pkg::NUM_TRAP-1:0] trap_req,
   // core side
   input  wire logic [eipu_pkg::LVL_W-1:0]    core_run_level,
   output logic                               irq_valid,
   output logic [eipu_pkg::ID_W-1:0]          irq_id,
   output logic [eipu_pkg::LVL_W-1:0]         irq_level,
   output logic                               wake,
   output logic                               irq
);
   import eipu_pkg::*;

   // *********************************************************************
   // register bus
   // *********************************************************************
   logic [AW-1:0]    awaddr_r;
   logic [7:0]       wdata_r;
   logic             wstrb0_r;
   logic             aw_have_r;
   logic             w_have_r;
   logic             bvalid_r;
   logic [1:0]       bresp_r;
   logic             rvalid_r;
   logic [1:0]       rresp_r;
   logic [31:0]      rdata_r;
   logic             wr_fire;
   logic             wr_hit;
   logic [7:0]       enl_r;
   logic [7:0]       enh_r;
   logic [7:0]       pri_r [8];
   logic [NUM_SW-1:0] srq_r;
   logic [NUM_SW-1:0] sen_r;
   logic [ST_W-1:0]  ist_r;
   logic [ST_W-1:0]  imsk_r;
   logic             valid_r;
   logic [ID_W-1:0]  id_r;
   logic [LVL_W-1:0] level_r;
   logic             wake_r;

   assign s_axi_awready = !aw_have_r && !bvalid_r;
   assign s_axi_wready  = !w_have_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   assign wr_fire = aw_have_r && w_have_r && !bvalid_r;

   function automatic logic reg_hit(input logic [AW-1:0] a);
      reg_hit = (a[AW-1:2] <= OFS_STAT[AW-1:2]) ||
                (a[AW-1:5] == OFS_PRI0[AW-1:5]);
   endfunction

   assign wr_hit = wr_fire && wstrb0_r && reg_hit(awaddr_r);

   // address and data are taken in either order, answered once both held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb0_r  <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= reg_hit(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   // read data; reserved bits and the missing priority register read zero
   function automatic logic [7:0] rd_mux(input logic [AW-1:0] a);
      logic [AW-1:0] w;
      w = {a[AW-1:2], 2'b00};
      rd_mux = 8'h00;
      if (w[AW-1:5] == OFS_PRI0[AW-1:5])
         rd_mux = pri_r[a[4:2]];
      else if (w == OFS_ENL)
         rd_mux = enl_r;
      else if (w == OFS_ENH)
         rd_mux = enh_r;
      else if (w == OFS_SRQ)
         rd_mux = {1'b0, srq_r};
      else if (w == OFS_SEN)
         rd_mux = {1'b0, sen_r};
      else if (w == OFS_IST)
         rd_mux = {4'h0, ist_r};
      else if (w == OFS_IMSK)
         rd_mux = {4'h0, imsk_r};
      else if (w == OFS_STAT)
         rd_mux = {level_r, core_run_level};
   endfunction

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rresp_r  <= RESP_OKAY;
         rdata_r  <= '0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_r  <= {24'h000000, rd_mux(s_axi_araddr)};
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // *********************************************************************
   // enable, priority and software interrupt registers
   // *********************************************************************
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enl_r <= '0;
         enh_r <= '0;
         sen_r <= '0;
         srq_r <= '0;
         for (int k = 0; k < 8; k++)
            pri_r[k] <= '0;
      end
      else if (wr_hit)
      begin
         if (awaddr_r[AW-1:5] == OFS_PRI0[AW-1:5])
         begin
            if (awaddr_r[4:2] != PRI_HOLE)
               pri_r[awaddr_r[4:2]] <= wdata_r & PRI_MASK;
         end
         else
         begin
            case ({awaddr_r[AW-1:2], 2'b00})
               OFS_ENL: enl_r <= wdata_r & ENL_MASK;
               OFS_ENH: enh_r <= wdata_r & ENH_MASK;
               OFS_SRQ: srq_r <= wdata_r[NUM_SW-1:0];
               OFS_SEN: sen_r <= wdata_r[NUM_SW-1:0];
               default: ;
            endcase
         end
      end
   end

   // *********************************************************************
   // candidate levels
   // *********************************************************************
   logic [15:0]             en_slot;
   logic [NUM_EV-1:0]       ev_live;
   logic [NUM_EV*LVL_W-1:0] ev_lvl;
   logic [NUM_SW*LVL_W-1:0] sw_lvl;
   logic [NUM_NMI*LVL_W-1:0] nmi_lvl;
   logic [NUM_NMI-1:0]      nmi_req;

   assign en_slot = {enh_r, enl_r};
   assign nmi_req = {trap_req, exc_req};

   genvar g;
   generate
      for (g = 0; g < NUM_EV; g++)
      begin : g_ev
         logic [7:0]      pr;
         logic [PF_W-1:0] fld;
         assign pr  = pri_r[EV_SLOT[g][3:1]];
         assign fld = EV_SLOT[g][0] ? pr[PF_HI +: PF_W] : pr[PF_W-1:0];
         // zero field stays level 0 and can never win
         assign ev_lvl[g*LVL_W +: LVL_W] = (fld == '0) ? '0 :
                LVL_EV_BAS + {1'b0, fld};
         assign ev_live[g] = ev_req[g] && en_slot[EV_SLOT[g]] &&
                enl_r[GEN_BIT];
      end
      for (g = 0; g < NUM_SW; g++)
      begin : g_sw
         assign sw_lvl[g*LVL_W +: LVL_W] = LVL_W'(g + 1);
      end
      for (g = 0; g < NUM_NMI; g++)
      begin : g_nmi
         assign nmi_lvl[g*LVL_W +: LVL_W] = LVL_NMI;
      end
   endgenerate

   // *********************************************************************
   // arbitration
   // *********************************************************************
   logic             ev_found;
   logic [3:0]       ev_idx;
   logic [LVL_W-1:0] ev_best;
   logic             sw_found;
   logic [2:0]       sw_idx;
   logic [LVL_W-1:0] sw_best;
   logic             nmi_found;
   logic [4:0]       nmi_idx;
   logic             ev_ok;
   logic             sw_ok;
   logic             valid_nxt;
   logic [ID_W-1:0]  id_nxt;
   logic [LVL_W-1:0] level_nxt;

   eipu_arb #(.N(NUM_EV), .IW(4)) u_ev_arb (
      .req   (ev_live),
      .lvl   (ev_lvl),
      .found (ev_found),
      .idx   (ev_idx),
      .best  (ev_best)
   );

   eipu_arb #(.N(NUM_SW), .IW(3)) u_sw_arb (
      .req   (srq_r & sen_r),
      .lvl   (sw_lvl),
      .found (sw_found),
      .idx   (sw_idx),
      .best  (sw_best)
   );

   // equal levels, so index order gives reset first, then the rest
   eipu_arb #(.N(NUM_NMI), .IW(5)) u_nmi_arb (
      .req   (nmi_req),
      .lvl   (nmi_lvl),
      .found (nmi_found),
      .idx   (nmi_idx),
      .best  ()
   );

   // an event or software request needs a strictly higher level; traps and exceptions take the core at any level
   assign ev_ok = ev_found && (ev_best > core_run_level);
   assign sw_ok = sw_found && (sw_best > core_run_level);

   always_comb
   begin
      valid_nxt = 1'b0;
      id_nxt    = '0;
      level_nxt = '0;
      if (nmi_found)
      begin
         valid_nxt = 1'b1;
         id_nxt    = ID_EXC + {1'b0, nmi_idx};
         level_nxt = LVL_NMI;
      end
      else if (ev_ok)
      begin
         valid_nxt = 1'b1;
         id_nxt    = ID_EV + {2'b00, ev_idx};
         level_nxt = ev_best;
      end
      else if (sw_ok)
      begin
         valid_nxt = 1'b1;
         id_nxt    = ID_SW + {3'b000, sw_idx};
         level_nxt = sw_best;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         valid_r <= 1'b0;
         id_r    <= '0;
         level_r <= '0;
      end
      else
      begin
         valid_r <= valid_nxt;
         id_r    <= id_nxt;
         level_r <= level_nxt;
      end
   end

   assign irq_valid = valid_r;
   assign irq_id    = id_r;
   assign irq_level = level_r;

   // *********************************************************************
   // power-down wake and interrupt status
   // *********************************************************************
   logic            wake_nxt;
   logic            new_win;
   logic [ST_W-1:0] ist_set;
   logic [ST_W-1:0] ist_clr;

   assign wake_nxt = (ev_req[EXT0] && enl_r[EXT0] && ext_lvl_mode[0]) ||
                     (ev_req[EXT1] && enl_r[EXT1] && ext_lvl_mode[1]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         wake_r <= 1'b0;
      else
         wake_r <= wake_nxt;
   end

   assign wake    = wake_r;
   assign new_win = valid_nxt && (!valid_r || (id_nxt != id_r));
   assign ist_set = {wake_nxt && !wake_r,
                     new_win && nmi_found,
                     new_win && !nmi_found && !ev_ok,
                     new_win && !nmi_found && ev_ok};
   assign ist_clr = (wr_hit && ({awaddr_r[AW-1:2], 2'b00} == OFS_IST)) ?
                    wdata_r[ST_W-1:0] : '0;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ist_r  <= '0;
         imsk_r <= '0;
      end
      else
      begin
         ist_r <= (ist_r & ~ist_clr) | ist_set;
         if (wr_hit && ({awaddr_r[AW-1:2], 2'b00} == OFS_IMSK))
            imsk_r <= wdata_r[ST_W-1:0];
      end
   end

   assign irq = |(ist_r & imsk_r);

   // *********************************************************************
   // assertions
   // *********************************************************************
   logic is_ev_r;
   logic is_sw_r;
   assign is_ev_r = valid_r && (id_r >= ID_EV) && (id_r < ID_SW);
   assign is_sw_r = valid_r && (id_r >= ID_SW);

   // software requests that were live when the offered source was chosen
   logic [NUM_SW-1:0] sw_live_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sw_live_r <= '0;
      else
         sw_live_r <= srq_r & sen_r;
   end

   sequence s_wr_both;
      aw_have_r && w_have_r && !bvalid_r;
   endsequence

   a_global_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      is_ev_r |-> $past(enl_r[GEN_BIT]))
      else $error("event delivered with global enable off");
   a_run_above: assert property (@(posedge aclk) disable iff (!aresetn)
      (valid_r && (id_r >= ID_EV)) |-> (level_r > $past(core_run_level)))
      else $error("delivered level not above running level");
   a_event_range: assert property (@(posedge aclk) disable iff (!aresetn)
      is_ev_r |-> (level_r >= LVL_EV_MIN))
      else $error("event delivered below level 9");
   a_soft_range: assert property (@(posedge aclk) disable iff (!aresetn)
      is_sw_r |-> (level_r >= 4'h1 && level_r <= LVL_SW_MAX))
      else $error("software level out of range");
   a_soft_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      is_sw_r |-> sw_live_r[3'(id_r - ID_SW)])
      else $error("software interrupt without request and enable");
   a_nmi_first: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(|nmi_req) |-> (valid_r && id_r < ID_EV))
      else $error("trap or exception not delivered first");
   a_event_beats: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(ev_ok && sw_ok && !nmi_found) |-> is_ev_r)
      else $error("software interrupt beat an event");
   a_reset_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(!aresetn) |-> (enl_r == '0 && enh_r == '0 && sen_r == '0))
      else $error("enables not cleared by reset");
   a_wake_cond: assert property (@(posedge aclk) disable iff (!aresetn)
      wake_r |-> $past(enl_r[EXT0] || enl_r[EXT1]))
      else $error("wake without enabled external interrupt");
   a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_wr_both |=> bvalid_r ##0 (!aw_have_r && !w_have_r))
      else $error("write not answered after address and data");

endmodule

// File: test/eipu_far_model.sv
// model of the peripherals and the core that face the interrupt unit
// assumes bench commands on aclk; DLY stages make the far side answer slowly
`timescale 1ns/100ps
module eipu_far_model #(
   parameter int DLY = 2
) (
   // clock
   input  wire logic        aclk,
   // bench commands: run level, traps, exceptions, modes, events
   input  wire logic [40:0] cmd,
   // levels seen by the unit
   output logic [40:0]      pins
);
   logic [40:0] pipe_r [DLY];

   // each request level is passed on unchanged after DLY register stages
   always_ff @(posedge aclk)
   begin
      pipe_r[0] <= cmd;
      for (int i = 1; i < DLY; i++)
         pipe_r[i] <= pipe_r[i-1];
   end

   assign pins = pipe_r[DLY-1];
endmodule

// File: test/test_event_interrupt_priority_unit.sv
// self-checking bench of the event interrupt priority unit
// assumes one 40 MHz clock; the far-side model feeds all request inputs
`timescale 1ns/100ps
module test_event_interrupt_priority_unit;
   import eipu_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
   logic        s_axi_rready = 1'b1;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, irq_valid, wake, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [5:0]  irq_id;
   logic [3:0]  irq_level;
   logic [40:0] cmd = '0;
   logic [40:0] pins;
   logic        look = 1'b0;
   logic [33:0] exp_q [$];
   int          miscompares = 0;
   int          checked = 0;

   always #12.5 aclk = ~aclk;

   eipu_far_model #(.DLY(2)) i_far (.aclk(aclk), .cmd(cmd), .pins(pins));

   eipu_top i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ev_req(pins[12:0]),
      .ext_lvl_mode(pins[14:13]), .exc_req(pins[20:15]),
      .trap_req(pins[36:21]), .core_run_level(pins[40:37]),
      .irq_valid(irq_valid), .irq_id(irq_id), .irq_level(irq_level),
      .wake(wake), .irq(irq));

   task automatic give_verdict();
      if (miscompares == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(string what, logic [33:0] seen, logic [33:0] want);
      checked++;
      if (seen !== want)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask

   // ***********************************************************
   // monitor: oldest note against each result
   // ***********************************************************
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         check("read word", {s_axi_rresp, s_axi_rdata},
               exp_q.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         check("write resp", {32'h0, s_axi_bresp},
               exp_q.pop_front());
      if (look)
         check("delivery", {21'h0, wake, irq, irq_valid,
               irq_valid ? irq_id : 6'h00, irq_level}, exp_q.pop_front());
   end

   // ready and valid only move at rising edges, so the falling edge
   // shows what the next rising edge samples; returns after that edge
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      @(negedge aclk);
      while (s !== 1'b1)
      begin
         n++;
         if (n > 100)
         begin
            miscompares++;
            give_verdict();
         end
         @(negedge aclk);
      end
      @(posedge aclk);
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d,
                     logic [1:0] rsp = RESP_OKAY);
      bit aw_ok, w_ok, aw_hit, w_hit;
      aw_ok = 0;
      w_ok = 0;
      exp_q.push_back({32'h0, rsp});
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h0, d};
      s_axi_wvalid <= 1'b1;
      for (int n = 0; !(aw_ok && w_ok); n++)
      begin
         if (n > 100)
         begin
            miscompares++;
            give_verdict();
         end
         @(negedge aclk);
         aw_hit = !aw_ok && s_axi_awready;
         w_hit = !w_ok && s_axi_wready;
         @(posedge aclk);
         if (aw_hit)
         begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (w_hit)
         begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      wait_hi(s_axi_bvalid);
   endtask

   task automatic rd(logic [7:0] a, logic [33:0] want);
      exp_q.push_back(want);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      wait_hi(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid);
   endtask

   // let requests pass the far side and the unit, then note the result
   task automatic expect_irq(logic wk, logic iq, logic [5:0] id,
                             logic [3:0] lv);
      repeat (4) @(posedge aclk);
      exp_q.push_back({21'h0, wk, iq, lv != 4'h0,
                       (lv != 4'h0) ? id : 6'h00, lv});
      look <= 1'b1;
      @(posedge aclk);
      look <= 1'b0;
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial
   begin
      logic [6:0] r;
      logic [3:0] lv;
      void'($urandom(43935));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_ENL, 34'h0);
      rd(OFS_ENH, 34'h0);
      rd(OFS_SEN, 34'h0);
      rd(8'h1C, {RESP_SLVERR, 32'h0});
      wr(8'h1C, 8'hFF, RESP_SLVERR);
      wr(OFS_PRI0, 8'h01);
      cmd[0] <= 1'b1;
      expect_irq(0, 0, ID_EV, 4'h0);
      wr(OFS_ENL, 8'h80);
      expect_irq(0, 0, ID_EV, 4'h0);
      wr(OFS_ENL, 8'h01);
      expect_irq(0, 0, ID_EV, 4'h0);
      wr(OFS_ENL, 8'h83);
      for (int f = 1; f < 8; f++)
      begin
         wr(OFS_PRI0, 8'(f));
         expect_irq(0, 0, ID_EV, LVL_EV_BAS + 4'(f));
      end
      wr(OFS_PRI0, 8'h00);
      expect_irq(0, 0, ID_EV, 4'h0);
      cmd[1] <= 1'b1;
      wr(OFS_PRI0, 8'h52);
      expect_irq(0, 0, ID_EV + 6'h01, 4'hD);
      wr(OFS_PRI0, 8'h55);
      expect_irq(0, 0, ID_EV, 4'hD);
      cmd[40:37] <= 4'hD;
      expect_irq(0, 0, ID_EV, 4'h0);
      wr(OFS_PRI0, 8'h57);
      expect_irq(0, 0, ID_EV, 4'hF);
      cmd[40:37] <= 4'h0;
      cmd[1:0] <= 2'h0;
      wr(OFS_SEN, 8'h7F);
      for (int k = 0; k < 6; k++)
      begin
         r = 7'($urandom());
         lv = 4'h0;
         for (int b = 0; b < 7; b++)
            if (r[b])
               lv = 4'(b + 1);
         wr(OFS_SRQ, {1'b0, r});
         expect_irq(0, 0, ID_SW + 6'(lv) - 6'h01, lv);
      end
      wr(OFS_SRQ, 8'h7F);
      cmd[0] <= 1'b1;
      wr(OFS_PRI0, 8'h01);
      expect_irq(0, 0, ID_EV, LVL_EV_MIN);
      wr(OFS_ENL, 8'h00);
      cmd[40:37] <= 4'hF;
      cmd[24] <= 1'b1;
      expect_irq(0, 0, 6'h09, LVL_NMI);
      cmd[15] <= 1'b1;
      expect_irq(0, 0, ID_EXC, LVL_NMI);
      cmd[40:15] <= '0;
      wr(OFS_SRQ, 8'h00);
      cmd[13] <= 1'b1;
      wr(OFS_ENL, 8'h01);
      expect_irq(1, 0, ID_EV, 4'h0);
      cmd[13] <= 1'b0;
      expect_irq(0, 0, ID_EV, 4'h0);
      wr(OFS_IST, 8'h0F);
      wr(OFS_IMSK, 8'h01);
      wr(OFS_ENL, 8'h81);
      expect_irq(0, 1, ID_EV, LVL_EV_MIN);
      rd(OFS_IST, 34'h1);
      wr(OFS_IST, 8'h01);
      expect_irq(0, 0, ID_EV, LVL_EV_MIN);
      wr(OFS_SEN, 8'h7F);
      // a reset in mid-run must drop every enable set so far
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(OFS_ENL, 34'h0);
      rd(OFS_SEN, 34'h0);
      expect_irq(0, 0, ID_EV, 4'h0);
      repeat (2) @(posedge aclk);
      give_verdict();
   end
endmodule
